// [rtl/hpfc_host_port_flow_ctrl_reg.v]
// Summary of operation
// - While the fifo level coupling bit is set, the host receive fifo level drives the switch transmitter and the switch receive fifo level drives the host transmitter.
// - Bit 6 is a read/write backpressure enable that turns half-duplex backpressure on the host port on or off.
// - Bit 5 reads the duplex in force on the host port, 0 for full and 1 for half.
// - Bit 4 reads 1 while receive pause is active on the host port and 0 otherwise.
// - Bit 3 reads 1 while transmit pause is active on the host port and 0 otherwise.
// - Bit 2 enables pause frame detection, but only when manual select is set or negotiation is off.
// - The register is one 32-bit word at offset 1A8h whose status bits show the settings in force.
// - A write to this register never alters the pause capability of the advertisement register.
// - Bit 1 permits pause frame generation, but only when manual select is set or negotiation is off.
// - With manual select clear and negotiation on, the negotiated result governs and the pause enables in bits 2 and 1 are ignored.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "hpfc_defs.vh"

module hpfc_host_port_flow_ctrl_reg (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`HPFC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire strap_manual_select,
  input wire strap_backpressure,
  input wire strap_pause_enable,
  input wire strap_reload,
  input wire vphy_an_enable,
  input wire vphy_an_half_duplex,
  input wire vphy_forced_half_duplex,
  input wire vphy_an_rx_pause,
  input wire vphy_an_tx_pause,
  input wire host_rx_fifo_level_high,
  input wire switch_rx_fifo_level_high,
  output reg host_port_fifo_level_coupling,
  output reg host_port_backpressure,
  output reg host_port_rx_pause_active,
  output reg host_port_tx_pause_active,
  output reg host_port_half_duplex,
  output reg switch_tx_hold,
  output reg host_tx_hold
);

  // ****************************************************************
  // Start-up states.
  // ****************************************************************
  localparam [3:0] ST_WAIT1 = 4'b0001;
  localparam [3:0] ST_WAIT2 = 4'b0010;
  localparam [3:0] ST_WAIT3 = 4'b0100;
  localparam [3:0] ST_RUN = 4'b1000;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  function hit_flow_ctrl;
    input [`HPFC_ADDR_W-1:0] addr;
    begin
      if (addr == `HPFC_FLOW_CTRL_OFFSET) begin
        hit_flow_ctrl = 1'b1;
      end else begin
        hit_flow_ctrl = 1'b0;
      end
    end
  endfunction

  // ****************************************************************
  // Synchronised pins.
  // ****************************************************************
  wire [7:0] pins_s;
  wire strap_manual_s;
  wire strap_bp_s;
  wire strap_pause_s;
  wire an_en_s;
  wire an_half_s;
  wire forced_half_s;
  wire an_rx_s;
  wire an_tx_s;

  hpfc_sync #(
    .WIDTH(8)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({strap_manual_select, strap_backpressure, strap_pause_enable, vphy_an_enable,
               vphy_an_half_duplex, vphy_forced_half_duplex, vphy_an_rx_pause,
               vphy_an_tx_pause}),
    .sync_out(pins_s)
  );

  assign strap_manual_s = pins_s[7];
  assign strap_bp_s = pins_s[6];
  assign strap_pause_s = pins_s[5];
  assign an_en_s = pins_s[4];
  assign an_half_s = pins_s[3];
  assign forced_half_s = pins_s[2];
  assign an_rx_s = pins_s[1];
  assign an_tx_s = pins_s[0];

  // ****************************************************************
  // Strap capture sequence.
  // ****************************************************************
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg strap_load;

  always @* begin
    state_d = state_q;
    strap_load = 1'b0;
    case (state_q)
      ST_WAIT1: begin
        state_d = ST_WAIT2;
      end
      ST_WAIT2: begin
        state_d = ST_WAIT3;
      end
      // The straps leave the synchroniser after two edges, so they load at the third.
      ST_WAIT3: begin
        state_d = ST_RUN;
        strap_load = 1'b1;
      end
      ST_RUN: begin
        strap_load = strap_reload;
      end
      default: begin
        state_d = ST_WAIT1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_WAIT1;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Control fields.
  // ****************************************************************
  reg fifo_couple_q;
  reg bp_en_q;
  reg rx_en_q;
  reg tx_en_q;
  reg manual_q;
  reg fifo_couple_d;
  reg bp_en_d;
  reg rx_en_d;
  reg tx_en_d;
  reg manual_d;
  wire wr_hit;

  // The write decode touches only this word, so no other register sees the data.
  assign wr_hit = psel & penable & pwrite & pready & hit_flow_ctrl(paddr) & pstrb[0];

  // ****************************************************************
  // Next values of the control fields.
  // ****************************************************************
  always @* begin
    fifo_couple_d = fifo_couple_q;
    bp_en_d = bp_en_q;
    rx_en_d = rx_en_q;
    tx_en_d = tx_en_q;
    manual_d = manual_q;
    if (wr_hit) begin
      fifo_couple_d = pwdata[`HPFC_BIT_FIFO_COUPLE];
      bp_en_d = pwdata[`HPFC_BIT_BP_EN];
      rx_en_d = pwdata[`HPFC_BIT_RX_PAUSE_EN];
      tx_en_d = pwdata[`HPFC_BIT_TX_PAUSE_EN];
      manual_d = pwdata[`HPFC_BIT_MANUAL_SEL];
    end else if (strap_load) begin
      bp_en_d = strap_bp_s;
      rx_en_d = strap_pause_s;
      tx_en_d = strap_pause_s;
      manual_d = strap_manual_s;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_couple_q <= `HPFC_RST_FIFO_COUPLE;
      bp_en_q <= `HPFC_RST_BP_EN;
      rx_en_q <= `HPFC_RST_PAUSE_EN;
      tx_en_q <= `HPFC_RST_PAUSE_EN;
      manual_q <= `HPFC_RST_MANUAL_SEL;
    end else begin
      fifo_couple_q <= fifo_couple_d;
      bp_en_q <= bp_en_d;
      rx_en_q <= rx_en_d;
      tx_en_q <= tx_en_d;
      manual_q <= manual_d;
    end
  end

  // ****************************************************************
  // Settings in force.
  // ****************************************************************
  wire use_manual;
  wire half_now;
  wire rx_now;
  wire tx_now;

  assign use_manual = manual_q | ~an_en_s;
  assign half_now = an_en_s ? an_half_s : forced_half_s;
  assign rx_now = ~half_now & (use_manual ? rx_en_q : an_rx_s);
  assign tx_now = ~half_now & (use_manual ? tx_en_q : an_tx_s);

  // ****************************************************************
  // Output next values.
  // ****************************************************************
  wire couple_out_d;
  wire backpressure_d;
  wire rx_active_d;
  wire tx_active_d;
  wire half_duplex_d;
  wire switch_hold_d;
  wire host_hold_d;

  assign couple_out_d = fifo_couple_q;
  assign backpressure_d = bp_en_q & half_now;
  assign rx_active_d = rx_now;
  assign tx_active_d = tx_now;
  assign half_duplex_d = half_now;
  assign switch_hold_d = fifo_couple_q & host_rx_fifo_level_high;
  assign host_hold_d = fifo_couple_q & switch_rx_fifo_level_high;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_port_fifo_level_coupling <= 1'b0;
      host_port_backpressure <= 1'b0;
      host_port_rx_pause_active <= 1'b0;
      host_port_tx_pause_active <= 1'b0;
      host_port_half_duplex <= 1'b0;
      switch_tx_hold <= 1'b0;
      host_tx_hold <= 1'b0;
    end else begin
      host_port_fifo_level_coupling <= couple_out_d;
      host_port_backpressure <= backpressure_d;
      host_port_rx_pause_active <= rx_active_d;
      host_port_tx_pause_active <= tx_active_d;
      host_port_half_duplex <= half_duplex_d;
      switch_tx_hold <= switch_hold_d;
      host_tx_hold <= host_hold_d;
    end
  end

  // ****************************************************************
  // Read word.
  // ****************************************************************
  wire [31:0] rd_word;

  assign rd_word[31:`HPFC_BIT_FIFO_COUPLE+1] = {`HPFC_RESERVED_W{1'b0}};
  assign rd_word[`HPFC_BIT_FIFO_COUPLE] = fifo_couple_q;
  assign rd_word[`HPFC_BIT_BP_EN] = bp_en_q;
  assign rd_word[`HPFC_BIT_CUR_DUPLEX] = half_now;
  assign rd_word[`HPFC_BIT_RX_PAUSE_ACT] = rx_now;
  assign rd_word[`HPFC_BIT_TX_PAUSE_ACT] = tx_now;
  assign rd_word[`HPFC_BIT_RX_PAUSE_EN] = rx_en_q;
  assign rd_word[`HPFC_BIT_TX_PAUSE_EN] = tx_en_q;
  assign rd_word[`HPFC_BIT_MANUAL_SEL] = manual_q;

  // ****************************************************************
  // Bus answer.
  // ****************************************************************
  wire setup;
  wire rd_hit;
  reg pready_d;
  reg pslverr_d;
  reg [31:0] prdata_d;

  assign setup = psel & ~penable & ~pready;
  assign rd_hit = ~pwrite & hit_flow_ctrl(paddr);

  always @* begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = `HPFC_RST_WORD;
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = ~hit_flow_ctrl(paddr);
      if (rd_hit) begin
        prdata_d = rd_word;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `HPFC_RST_WORD;
    end else begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
  end

endmodule // hpfc_host_port_flow_ctrl_reg

// [rtl/hpfc_defs.vh]
`ifndef HPFC_DEFS_VH
`define HPFC_DEFS_VH

// ****************************************************************
// Register map.
// ****************************************************************
`define HPFC_ADDR_W 12
`define HPFC_FLOW_CTRL_OFFSET 12'h1A8

// ****************************************************************
// Field positions.
// ****************************************************************
`define HPFC_BIT_MANUAL_SEL 0
`define HPFC_BIT_TX_PAUSE_EN 1
`define HPFC_BIT_RX_PAUSE_EN 2
`define HPFC_BIT_TX_PAUSE_ACT 3
`define HPFC_BIT_RX_PAUSE_ACT 4
`define HPFC_BIT_CUR_DUPLEX 5
`define HPFC_BIT_BP_EN 6
`define HPFC_BIT_FIFO_COUPLE 7
`define HPFC_RESERVED_W 24

// ****************************************************************
// Reset values.
// ****************************************************************
`define HPFC_RST_FIFO_COUPLE 1'h0
`define HPFC_RST_BP_EN 1'h0
`define HPFC_RST_PAUSE_EN 1'h0
`define HPFC_RST_MANUAL_SEL 1'h0
`define HPFC_RST_WORD 32'h00000000

// ****************************************************************
// Timing counts.
// ****************************************************************
`define HPFC_SYNC_STAGES 2

`endif

// [rtl/hpfc_sync.v]
`timescale 1ns/1ns
`include "hpfc_defs.vh"

// ****************************************************************
// Two-stage synchroniser, one chain per bit.
// ****************************************************************
module hpfc_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule // hpfc_sync

// [verif/hpfc_props.sv]
`timescale 1ns/1ns
`include "hpfc_defs.vh"

module hpfc_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [`HPFC_ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire host_rx_fifo_level_high,
  input wire switch_rx_fifo_level_high,
  input wire host_port_fifo_level_coupling,
  input wire host_port_backpressure,
  input wire host_port_rx_pause_active,
  input wire host_port_tx_pause_active,
  input wire host_port_half_duplex,
  input wire switch_tx_hold,
  input wire host_tx_hold
);
  // ****************************************************************
  // Checks on the bus and the flow control outputs.
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_setup_answered: assert property (psel && !penable && !pready |=> pready)
    else $error("setup not answered next cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready stood more than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr != `HPFC_FLOW_CTRL_OFFSET))
    else $error("error flag does not match address");
  a_reserved_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("reserved bits read nonzero");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside access cycle");
  a_switch_hold: assert property ($stable(host_port_fifo_level_coupling) |->
    switch_tx_hold == (host_port_fifo_level_coupling && $past(host_rx_fifo_level_high)))
    else $error("switch transmitter hold wrong");
  a_host_hold: assert property ($stable(host_port_fifo_level_coupling) |->
    host_tx_hold == (host_port_fifo_level_coupling && $past(switch_rx_fifo_level_high)))
    else $error("host transmitter hold wrong");
  a_bp_half_only: assert property (host_port_backpressure |-> host_port_half_duplex)
    else $error("backpressure in full duplex");
  a_pause_full_only: assert property (host_port_rx_pause_active || host_port_tx_pause_active
    |-> !host_port_half_duplex)
    else $error("pause active in half duplex");

  c_error: cover property (pready && pslverr);
  c_read_ok: cover property (pready && !pslverr);
  c_coupled: cover property (switch_tx_hold);
endmodule // hpfc_props

bind hpfc_host_port_flow_ctrl_reg hpfc_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .host_rx_fifo_level_high(host_rx_fifo_level_high),
  .switch_rx_fifo_level_high(switch_rx_fifo_level_high),
  .host_port_fifo_level_coupling(host_port_fifo_level_coupling),
  .host_port_backpressure(host_port_backpressure),
  .host_port_rx_pause_active(host_port_rx_pause_active),
  .host_port_tx_pause_active(host_port_tx_pause_active),
  .host_port_half_duplex(host_port_half_duplex), .switch_tx_hold(switch_tx_hold),
  .host_tx_hold(host_tx_hold));

// [verif/hpfc_host_port_flow_ctrl_reg_tb_top.sv]
`timescale 1ns/1ns

module hpfc_host_port_flow_ctrl_reg_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic s_man, s_bp, s_pause, s_rld, an_en, an_half, f_half, an_rx, an_tx, h_lvl, s_lvl;
  logic cpl, bp, rx_act, tx_act, half, sw_hold, h_hold, e;
  int num_errors = 0;
  int tests_run = 0;

  hpfc_host_port_flow_ctrl_reg dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_manual_select(s_man),
    .strap_backpressure(s_bp), .strap_pause_enable(s_pause), .strap_reload(s_rld),
    .vphy_an_enable(an_en), .vphy_an_half_duplex(an_half), .vphy_forced_half_duplex(f_half),
    .vphy_an_rx_pause(an_rx), .vphy_an_tx_pause(an_tx), .host_rx_fifo_level_high(h_lvl),
    .switch_rx_fifo_level_high(s_lvl), .host_port_fifo_level_coupling(cpl),
    .host_port_backpressure(bp), .host_port_rx_pause_active(rx_act),
    .host_port_tx_pause_active(tx_act), .host_port_half_duplex(half),
    .switch_tx_hold(sw_hold), .host_tx_hold(h_hold));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      results();
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000, 4'hF);
    chk(r, x);
    chk({31'h0, e}, {31'h0, a != 12'h1A8});
  endtask

  task automatic outs(input logic [6:0] x);
    repeat (4) @(posedge pclk);
    chk({25'h0, cpl, bp, rx_act, tx_act, half, sw_hold, h_hold}, {25'h0, x});
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset_straps();
    repeat (3) @(posedge pclk);
    rd(12'h1A8, 32'h00000041);
  endtask

  task automatic t_write_fields();
    apb(1'b1, 12'h1A8, 32'hFFFFFFFF, 4'hF);
    rd(12'h1A8, 32'h000000DF);
    outs(7'b1011000);
    apb(1'b1, 12'h1A8, 32'h00000000, 4'hE);
    rd(12'h1A8, 32'h000000DF);
    rd(12'h1AC, 32'h00000000);
    apb(1'b1, 12'h1AC, 32'h00000000, 4'hF);
    rd(12'h1A8, 32'h000000DF);
  endtask

  task automatic t_negotiated();
    apb(1'b1, 12'h1A8, 32'h00000006, 4'hF);
    an_en <= 1'b1; an_tx <= 1'b1; an_rx <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h1A8, 32'h0000000E);
    apb(1'b1, 12'h1A8, 32'h00000046, 4'hF);
    an_half <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h1A8, 32'h00000066);
    outs(7'b0100100);
    an_en <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h1A8, 32'h0000005E);
    f_half <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h1A8, 32'h00000066);
    outs(7'b0100100);
    f_half <= 1'b0;
    s_man <= 1'b0; s_bp <= 1'b0; s_pause <= 1'b1;
    repeat (4) @(posedge pclk);
    s_rld <= 1'b1;
    @(posedge pclk);
    s_rld <= 1'b0;
    rd(12'h1A8, 32'h0000001E);
  endtask

  task automatic t_coupling();
    apb(1'b1, 12'h1A8, 32'h00000081, 4'hF);
    h_lvl <= 1'b1;
    outs(7'b1000010);
    h_lvl <= 1'b0; s_lvl <= 1'b1;
    outs(7'b1000001);
    rd(12'h1A8, 32'h00000081);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h00000000; pstrb = 4'h0; s_man = 1'b1; s_bp = 1'b1; s_pause = 1'b0;
    s_rld = 1'b0; an_en = 1'b0; an_half = 1'b0; f_half = 1'b0; an_rx = 1'b0;
    an_tx = 1'b0; h_lvl = 1'b0; s_lvl = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_straps();
    t_write_fields();
    t_negotiated();
    t_coupling();
    results();
  end
endmodule // hpfc_host_port_flow_ctrl_reg_tb_top
